// >>> io_power_pkg.sv
// constants for the io and power management register bank
package io_power_pkg;
  localparam logic [7:0] ADDR_WRITE  = 8'h39;
  localparam logic [7:0] ADDR_SET    = 8'h3A;
  localparam logic [7:0] ADDR_CLEAR  = 8'h3B;
  localparam int         SWAP_BIT    = 1;
  localparam int         SER_LVL_LO  = 2;
  localparam int         PLUS_PU_BIT = 4;
  localparam int         MINUS_PU_BIT = 5;
  localparam int         BUS_LVL_LO  = 6;
  localparam logic [7:0] WRITE_MASK  = 8'hFE;
  localparam logic [7:0] RESET_VALUE = 8'h04;
  localparam logic [1:0] LEVEL_3V3   = 2'h0;
  typedef enum logic [1:0] {MODE_BUS, MODE_SERIAL, MODE_AUDIO} phy_mode_t;
endpackage

// >>> io_power_if.sv
// register storage carrier between control logic and storage
`timescale 1ns/10ps
interface io_power_if;
  logic       wr_en;
  logic [7:0] wr_data;
  logic [7:0] value;
  modport ctrl (output wr_en, output wr_data, input value);
  modport store (input wr_en, input wr_data, output value);
endinterface

// >>> io_power_store.sv
// storage register for the io and power management byte
`timescale 1ns/10ps
module io_power_store
(
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  io_power_if.store   bus
);
  import io_power_pkg::*;
  logic [7:0] reg_ff;
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      reg_ff <= RESET_VALUE;
    else if (bus.wr_en)
      reg_ff <= bus.wr_data & WRITE_MASK;
  end
  assign bus.value = reg_ff;
endmodule // io_power_store

// >>> usb_io_power_management_register.sv
// io and power management register with pin routing and regulator select
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps

// Summary of operation
// - register reads at all three addresses; write, set, clear by address.
// - swap bit set exchanges plus and minus pin roles of the transceiver.
// - in serial mode swap bit exchanges which pin carries each serial path.
// - in audio mode speaker pins are never swapped.
// - serial level field bits 3:2 resets to 01, four voltage codes.
// - entering serial mode, level switches when serial transmit enable asserts.
// - audio mode holds regulator at 3.3V.
// - bits 4,5 enable pull-ups; serial mode forces both on.
// - bus level field bits 7:6 resets to 00, same encoding.
// - bus mode and the unused fourth mode code use the bus level field.
module usb_io_power_management_register
  import io_power_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // register port
  input  wire logic [7:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  // mode status from the transceiver core
  input  wire io_power_pkg::phy_mode_t mode_i,
  input  wire logic                  serial_transmit_enable_i,
  // pin routing
  input  wire logic                  core_plus_i,
  input  wire logic                  core_minus_i,
  output logic                       pin_plus_o,
  output logic                       pin_minus_o,
  input  wire logic                  spk_left_i,
  input  wire logic                  spk_right_i,
  output logic                       speaker_left_pin_o,
  output logic                       speaker_right_pin_o,
  // analogue controls
  output logic      [1:0]            regulator_level_o,
  output logic                       charger_pullup_plus_en_o,
  output logic                       charger_pullup_minus_en_o
);
  import io_power_pkg::*;

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  io_power_if regs ();

  io_power_store u_store
  (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .bus     (regs.store)
  );

  function automatic logic hit(input logic [7:0] a);
    hit = (a == ADDR_WRITE) || (a == ADDR_SET) || (a == ADDR_CLEAR);
  endfunction

  always_comb
  begin
    regs.wr_en   = 1'b0;
    regs.wr_data = regs.value;
    if (wr_i && addr_i == ADDR_WRITE)
    begin
      regs.wr_en   = 1'b1;
      regs.wr_data = wdata_i;
    end
    else if (wr_i && addr_i == ADDR_SET)
    begin
      regs.wr_en   = 1'b1;
      regs.wr_data = regs.value | wdata_i;
    end
    else if (wr_i && addr_i == ADDR_CLEAR)
    begin
      regs.wr_en   = 1'b1;
      regs.wr_data = regs.value & ~wdata_i;
    end
  end

  // unmapped addresses read zero; bit 0 is masked in storage
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else if (rd_i && hit(addr_i))
      rdata_o <= regs.value;
    else
      rdata_o <= 8'h00;
  end

  // ---------------------------------------------------------------
  // regulator level
  // ---------------------------------------------------------------
  logic       swap;
  logic [1:0] serial_level;
  logic [1:0] bus_level;
  logic       serial_armed_ff;

  assign swap         = regs.value[SWAP_BIT];
  assign serial_level = regs.value[SER_LVL_LO +: 2];
  assign bus_level    = regs.value[BUS_LVL_LO +: 2];

  // the serial level takes over only once transmit is enabled, so the
  // rail does not dip while the link is still switching modes
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      serial_armed_ff <= 1'b0;
    else if (mode_i != MODE_SERIAL)
      serial_armed_ff <= 1'b0;
    else if (serial_transmit_enable_i)
      serial_armed_ff <= 1'b1;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      regulator_level_o <= LEVEL_3V3;
    else
      case (mode_i)
        MODE_AUDIO:  regulator_level_o <= LEVEL_3V3;
        MODE_SERIAL:
          if (serial_armed_ff || serial_transmit_enable_i)
            regulator_level_o <= serial_level;
          else
            regulator_level_o <= bus_level;
        default:     regulator_level_o <= bus_level;
      endcase
  end

  // ---------------------------------------------------------------
  // pull-ups and pin routing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      charger_pullup_plus_en_o  <= 1'b0;
      charger_pullup_minus_en_o <= 1'b0;
    end
    else
    begin
      charger_pullup_plus_en_o  <= regs.value[PLUS_PU_BIT] || mode_i == MODE_SERIAL;
      charger_pullup_minus_en_o <= regs.value[MINUS_PU_BIT] || mode_i == MODE_SERIAL;
    end
  end

  // routing is combinational: the data path must not gain a cycle
  always_comb
  begin
    pin_plus_o  = swap ? core_minus_i : core_plus_i;
    pin_minus_o = swap ? core_plus_i : core_minus_i;
    speaker_left_pin_o  = spk_left_i;
    speaker_right_pin_o = spk_right_i;
  end
endmodule // usb_io_power_management_register

// >>> io_power_monitor.sv
// concurrent checks on the io and power register ports
`timescale 1ns/10ps
module io_power_monitor
  import io_power_pkg::*;
(
  // clock and register port
  input wire logic                    clk_i,
  input wire logic                    reset_i,
  input wire logic [7:0]              addr_i,
  input wire logic [7:0]              wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [7:0]              rdata_o,
  // mode and analogue controls
  input wire io_power_pkg::phy_mode_t mode_i,
  input wire logic [1:0]              regulator_level_o,
  input wire logic                    charger_pullup_plus_en_o,
  input wire logic                    charger_pullup_minus_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_wr_rd(a);
    wr_i && addr_i == a ##1 rd_i && addr_i == ADDR_WRITE;
  endsequence
  a_idle_read_zero: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not zero");
  a_unmapped_read: assert property (rd_i && addr_i > ADDR_CLEAR |=> rdata_o == 8'h00)
    else $error("unmapped rdata");
  a_bit0_zero: assert property (!rdata_o[0])
    else $error("bit 0 set");
  a_write_reads_back: assert property (s_wr_rd(ADDR_WRITE) |=>
    rdata_o == ($past(wdata_i, 2) & WRITE_MASK)) else $error("write lost");
  a_set_ors_in: assert property (s_wr_rd(ADDR_SET) |=>
    &(rdata_o | ~($past(wdata_i, 2) & WRITE_MASK))) else $error("set lost");
  a_clear_drops: assert property (s_wr_rd(ADDR_CLEAR) |=>
    !(rdata_o & $past(wdata_i, 2))) else $error("clear lost");
  a_audio_3v3: assert property (mode_i == MODE_AUDIO |=> regulator_level_o == LEVEL_3V3)
    else $error("audio level");
  a_serial_pullups: assert property (mode_i == MODE_SERIAL |=>
    charger_pullup_plus_en_o && charger_pullup_minus_en_o) else $error("pullups off");
endmodule // io_power_monitor
bind usb_io_power_management_register io_power_monitor mon (.*);

// >>> link_ctrl_model.sv
// link controller model driving the register port
`timescale 1ns/10ps
module link_ctrl_model
(
  input  wire logic       clk_i,
  output logic      [7:0] addr_o = 8'h00,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            wr_o = 1'b0,
  output logic            rd_o = 1'b0
);
  // strobes may follow back to back; idle releases them
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= !w;
  endtask
  task automatic idle;
    @(posedge clk_i);
    {wr_o, rd_o} <= 2'h0;
    addr_o       <= ~addr_o;
  endtask
endmodule // link_ctrl_model

// >>> usb_io_power_management_register_tb.sv
// self-checking bench for the io and power register
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module usb_io_power_management_register_tb;
  import io_power_pkg::*;
  logic       clk_i = 1'b0, reset_i = 1'b1, txen = 1'b0, rd_seen = 1'b0;
  logic       wr, rd, pp, pm, sl, sr, pu_p, pu_m;
  logic [3:0] pins = 4'h0;
  logic [7:0] addr, wdata, rdata, shadow, d, exp_rd;
  logic [1:0] lvl;
  logic [7:0] notes[$];
  phy_mode_t  mode = MODE_BUS;
  int         failures = 0, checked = 0, seed = 32'h6628B747;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) pins <= 4'($random(seed));
  link_ctrl_model lc (.clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  usb_io_power_management_register uut (.clk_i, .reset_i, .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mode_i(mode), .serial_transmit_enable_i(txen),
    .core_plus_i(pins[0]), .core_minus_i(pins[1]), .pin_plus_o(pp), .pin_minus_o(pm),
    .spk_left_i(pins[2]), .spk_right_i(pins[3]), .speaker_left_pin_o(sl),
    .speaker_right_pin_o(sr), .regulator_level_o(lvl), .charger_pullup_plus_en_o(pu_p),
    .charger_pullup_minus_en_o(pu_m));
  always @(posedge clk_i)
  begin
    if (rd_seen)
    begin
      exp_rd = notes.pop_front();
      `CHK("rdata", exp_rd, rdata)
    end
    rd_seen <= rd;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] e);
    if (!w) notes.push_back(e);
    lc.acc(w, a, e);
  endtask
  // regulator and pullups follow one cycle after their cause
  task automatic settle;
    lc.idle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic close_out;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #100us failures++;
    close_out();
  end
  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int a = 'h38; a < 'h3D; a++)
      acc(1'b0, 8'(a), (a inside {['h39:'h3B]}) ? RESET_VALUE : 8'h00);
    shadow = RESET_VALUE;
    for (int i = 0; i < 24; i++)
    begin
      d = 8'($random(seed));
      acc(1'b1, ADDR_WRITE + 8'(i % 4), d);
      shadow = (i % 4 == 0) ? d & WRITE_MASK : (i % 4 == 1) ? shadow | (d & WRITE_MASK)
             : (i % 4 == 2) ? shadow & ~d : shadow;
      acc(1'b0, ADDR_WRITE + 8'(i % 3), shadow);
    end
    acc(1'b1, ADDR_WRITE, 8'hCA);
    settle();
    `CHK("bus lvl", 2'h3, lvl)
    `CHK("swap", {pins[1], pins[0], 2'h0}, {pp, pm, pu_p, pu_m})
    mode <= MODE_SERIAL;
    settle();
    `CHK("uart", {2'h3, pins[1], pins[0], 2'h3}, {lvl, pp, pm, pu_p, pu_m})
    txen <= 1'b1;
    settle();
    `CHK("uart lvl", 2'h2, lvl)
    mode <= MODE_AUDIO;
    settle();
    `CHK("audio", {2'h0, pins[2], pins[3]}, {lvl, sl, sr})
    reset_i <= 1'b1; // restore the register reset value, leaving audio mode
    @(posedge clk_i);
    reset_i <= 1'b0;
    txen    <= 1'b0;
    mode    <= MODE_BUS;
    acc(1'b1, ADDR_SET, 8'h20);
    acc(1'b0, ADDR_CLEAR, 8'h24);
    settle();
    `CHK("pullups", 4'h1, {lvl, pu_p, pu_m})
    close_out();
  end
endmodule // usb_io_power_management_register_tb
